// ### verilog/bru_pkg.sv
// Purpose: shared constants and types for the byte rotate unit
// Assumes: 8-bit datapath, one instruction per enabled clock
// Notes:   opcode codes are local to this unit
`default_nettype none

package bru_pkg;

  localparam int unsigned BRU_DATA_W = 8;
  localparam int unsigned BRU_MSB    = 7;
  localparam int unsigned BRU_LSB    = 0;

  localparam logic [7:0] BRU_WORK_RST  = 8'h00;
  localparam logic [7:0] BRU_MEM_RST   = 8'h00;
  localparam logic       BRU_CARRY_RST = 1'b0;

  // decoded opcode; 0 means no rotate this cycle
  typedef enum logic [2:0] {
    BRU_OP_NONE         = 3'h0,
    BRU_OP_LCARRY_MEM   = 3'h1,
    BRU_OP_LCARRY_WORK  = 3'h2,
    BRU_OP_RPLAIN_MEM   = 3'h3,
    BRU_OP_RPLAIN_WORK  = 3'h4,
    BRU_OP_RCARRY_MEM   = 3'h5,
    BRU_OP_RCARRY_WORK  = 3'h6
  } bru_op_t;

endpackage

`default_nettype wire

// ### verilog/bru_byte_rotate_unit.sv
// Purpose: rotate datapath slice of an 8-bit core (six rotate ops)
// Assumes: op_valid, op_code, operand, carry_in come from core logic
//          on sys_clk; no synchronisers needed
// Notes:   all results are registered; one op per enabled cycle
//
// Overview of operation
// - left via carry to memory: bit0 gets old carry, carry gets bit7.
// - left via carry to working register; carry gets bit7; memory kept.
// - plain right rotate to memory; bit0 goes to bit7; flags kept.
// - plain right rotate to working register; memory and flags kept.
// - right via carry to memory: bit7 gets old carry, carry gets bit0.
// - right via carry to working register; carry gets bit0; memory kept.
`default_nettype none

module bru_byte_rotate_unit
  import bru_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       op_valid,
  input  wire logic [2:0] op_code,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic      [7:0] working_register,
  output logic      [7:0] mem_wdata,
  output logic            mem_we,
  output logic            carry_out,
  output logic            carry_we,
  output logic            done
);

  typedef struct packed {
    logic [7:0] work;
    logic [7:0] mwd;
    logic       mwe;
    logic       cy;
    logic       cwe;
    logic       done;
  } bru_state_t;

  bru_state_t s_q;
  bru_state_t s_d;

  function automatic logic [7:0] rot_left(input logic [7:0] v,
                                          input logic       b0);
    rot_left = {v[BRU_MSB-1:BRU_LSB], b0};
  endfunction

  function automatic logic [7:0] rot_right(input logic [7:0] v,
                                           input logic       b7);
    rot_right = {b7, v[BRU_MSB:BRU_LSB+1]};
  endfunction

  always_comb begin
    s_d      = s_q;
    // strobes last one enabled cycle only
    s_d.mwe  = 1'b0;
    s_d.cwe  = 1'b0;
    s_d.done = 1'b0;
    if (op_valid) begin
      s_d.done = (op_code != BRU_OP_NONE);
      case (bru_op_t'(op_code))
        BRU_OP_LCARRY_MEM: begin
          s_d.mwd = rot_left(operand, carry_in);
          s_d.mwe = 1'b1;
          s_d.cy  = operand[BRU_MSB];
          s_d.cwe = 1'b1;
        end
        BRU_OP_LCARRY_WORK: begin
          s_d.work = rot_left(operand, carry_in);
          s_d.cy   = operand[BRU_MSB];
          s_d.cwe  = 1'b1;
        end
        BRU_OP_RPLAIN_MEM: begin
          s_d.mwd = rot_right(operand, operand[BRU_LSB]);
          s_d.mwe = 1'b1;
        end
        BRU_OP_RPLAIN_WORK: begin
          s_d.work = rot_right(operand, operand[BRU_LSB]);
        end
        BRU_OP_RCARRY_MEM: begin
          s_d.mwd = rot_right(operand, carry_in);
          s_d.mwe = 1'b1;
          s_d.cy  = operand[BRU_LSB];
          s_d.cwe = 1'b1;
        end
        BRU_OP_RCARRY_WORK: begin
          s_d.work = rot_right(operand, carry_in);
          s_d.cy   = operand[BRU_LSB];
          s_d.cwe  = 1'b1;
        end
        default: begin
          s_d.done = 1'b0;
        end
      endcase
    end
  end

  // all outputs update on the same edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{work: BRU_WORK_RST, mwd: BRU_MEM_RST, mwe: 1'b0,
               cy: BRU_CARRY_RST, cwe: 1'b0, done: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign working_register = s_q.work;
  assign mem_wdata        = s_q.mwd;
  assign mem_we           = s_q.mwe;
  assign carry_out        = s_q.cy;
  assign carry_we         = s_q.cwe;
  assign done             = s_q.done;

  // ---- assertions ----
  // checker-only helper; the datapath itself never reads it
  logic issue;
  assign issue = clk_en && op_valid;

  property p_ltc_mem;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_LCARRY_MEM |=> mem_we && carry_we &&
      mem_wdata == {$past(operand[6:0]), $past(carry_in)} &&
      carry_out == $past(operand[7]);
  endproperty
  a_ltc_mem: assert property (p_ltc_mem)
    else $error("left carry rotate to memory wrong");

  property p_ltc_work;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_LCARRY_WORK |=> !mem_we && carry_we &&
      working_register == {$past(operand[6:0]), $past(carry_in)} &&
      carry_out == $past(operand[7]);
  endproperty
  a_ltc_work: assert property (p_ltc_work)
    else $error("left carry rotate to working register wrong");

  property p_rpl_mem;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_RPLAIN_MEM |=> mem_we && !carry_we &&
      mem_wdata == {$past(operand[0]), $past(operand[7:1])} &&
      $stable(carry_out);
  endproperty
  a_rpl_mem: assert property (p_rpl_mem)
    else $error("right rotate to memory wrong");

  property p_rpl_work;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_RPLAIN_WORK |=> !mem_we && !carry_we &&
      working_register == {$past(operand[0]), $past(operand[7:1])} &&
      $stable(carry_out);
  endproperty
  a_rpl_work: assert property (p_rpl_work)
    else $error("right rotate to working register wrong");

  property p_rtc_mem;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_RCARRY_MEM |=> mem_we && carry_we &&
      mem_wdata == {$past(carry_in), $past(operand[7:1])} &&
      carry_out == $past(operand[0]);
  endproperty
  a_rtc_mem: assert property (p_rtc_mem)
    else $error("right carry rotate to memory wrong");

  property p_rtc_work;
    @(posedge sys_clk) disable iff (rst)
    issue && op_code == BRU_OP_RCARRY_WORK |=> !mem_we && carry_we &&
      working_register == {$past(carry_in), $past(operand[7:1])} &&
      carry_out == $past(operand[0]);
  endproperty
  a_rtc_work: assert property (p_rtc_work)
    else $error("right carry rotate to working register wrong");

  property p_one_cycle;
    @(posedge sys_clk) disable iff (rst)
    done && clk_en && !op_valid |=> !done && !mem_we && !carry_we;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("strobe held beyond one cycle");

  // strobes must stand through a frozen cycle, or the core loses them
  property p_idle_quiet;
    @(posedge sys_clk) disable iff (rst)
    !clk_en |=> $stable(working_register) && $stable(carry_out) &&
      $stable(mem_we) && $stable(carry_we) && $stable(done);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("state moved while clock enable low");

  // memory-destination ops must not disturb the working register
  property p_work_kept;
    @(posedge sys_clk) disable iff (rst)
    issue && (op_code == BRU_OP_LCARRY_MEM || op_code == BRU_OP_RPLAIN_MEM
      || op_code == BRU_OP_RCARRY_MEM) |=> $stable(working_register);
  endproperty
  a_work_kept: assert property (p_work_kept)
    else $error("memory rotate touched working register");

  property p_refused;
    @(posedge sys_clk) disable iff (rst)
    clk_en && (!op_valid || op_code == BRU_OP_NONE || op_code == 3'h7)
      |=> !done && !mem_we && !carry_we && $stable(working_register) &&
      $stable(carry_out);
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused op changed state");

  // reset wins over a low clock enable
  property p_reset_clear;
    @(posedge sys_clk)
    rst |=> working_register == BRU_WORK_RST && mem_wdata == BRU_MEM_RST &&
      carry_out == BRU_CARRY_RST && !mem_we && !carry_we && !done;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");

  c_ltc_mem:  cover property (@(posedge sys_clk)
    issue && op_code == BRU_OP_LCARRY_MEM);
  c_ltc_work: cover property (@(posedge sys_clk)
    issue && op_code == BRU_OP_LCARRY_WORK);
  c_rpl_work: cover property (@(posedge sys_clk)
    issue && op_code == BRU_OP_RPLAIN_WORK);
  c_rtc_b2b:  cover property (@(posedge sys_clk)
    issue && op_code == BRU_OP_RCARRY_MEM ##1 issue);
  c_freeze:   cover property (@(posedge sys_clk)
    done && !clk_en);

endmodule

`default_nettype wire

// ### dv/byte_rotate_unit_tb.sv
// Purpose: self-checking bench for the byte rotate unit
// Assumes: inputs driven at falling edges; bench plays the core
// Notes:   expected bytes are worked out by hand from bit moves
`default_nettype none
module byte_rotate_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bru_pkg::*;
  logic       sys_clk, rst, clk_en, op_valid, carry_in;
  logic [2:0] op_code;
  logic [7:0] operand, working_register, mem_wdata;
  logic       mem_we, carry_out, carry_we, done;
  int         n_errors, total_checks;

  bru_byte_rotate_unit bru_byte_rotate_unit_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .operand(operand), .carry_in(carry_in),
    .working_register(working_register), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .carry_out(carry_out), .carry_we(carry_we),
    .done(done));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic put(logic [2:0] op, logic [7:0] d, logic c);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code  = op;
    operand  = d;
    carry_in = c;
  endtask

  // one op, then idle; outputs looked at while the strobes stand
  task automatic issue(logic [2:0] op, logic [7:0] d, logic c);
    put(op, d, c);
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask

  task automatic strb(logic m, logic c, logic d);
    chk("mem_we", {7'h0, mem_we}, {7'h0, m});
    chk("carry_we", {7'h0, carry_we}, {7'h0, c});
    chk("done", {7'h0, done}, {7'h0, d});
  endtask

  // one reset cycle, then every output back at its reset value
  task automatic t_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk("working", working_register, BRU_WORK_RST);
    chk("mem_wdata", mem_wdata, BRU_MEM_RST);
    chk("carry_out", {7'h0, carry_out}, {7'h0, BRU_CARRY_RST});
    strb(1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_left_through_carry();
    issue(3'h1, 8'h81, 1'b0);
    chk("mem_wdata", mem_wdata, 8'h02);
    chk("carry_out", {7'h0, carry_out}, 8'h01);
    strb(1'b1, 1'b1, 1'b1);
    issue(3'h2, 8'h40, 1'b1);
    chk("working", working_register, 8'h81);
    chk("carry_out", {7'h0, carry_out}, 8'h00);
    strb(1'b0, 1'b1, 1'b1);
  endtask

  // carry is 0 here and the first operand's bit 0 is 1: a flag write would show
  task automatic t_plain_right();
    issue(3'h3, 8'h01, 1'b0);
    chk("mem_wdata", mem_wdata, 8'h80);
    chk("carry_out", {7'h0, carry_out}, 8'h00);
    strb(1'b1, 1'b0, 1'b1);
    issue(3'h4, 8'h02, 1'b1);
    chk("working", working_register, 8'h01);
    chk("carry_out", {7'h0, carry_out}, 8'h00);
    strb(1'b0, 1'b0, 1'b1);
  endtask

  // back to back: second op presented while first answers
  task automatic t_right_through_carry();
    put(3'h5, 8'h03, 1'b1);
    put(3'h6, 8'h81, 1'b0);
    chk("mem_wdata", mem_wdata, 8'h81);
    chk("carry_out", {7'h0, carry_out}, 8'h01);
    strb(1'b1, 1'b1, 1'b1);
    @(negedge sys_clk);
    op_valid = 1'b0;
    chk("working", working_register, 8'h40);
    chk("carry_out", {7'h0, carry_out}, 8'h01);
    strb(1'b0, 1'b1, 1'b1);
  endtask

  // codes 0 and 7, and a frozen cycle, must leave all alone
  task automatic t_refused();
    issue(3'h0, 8'hff, 1'b1);
    strb(1'b0, 1'b0, 1'b0);
    issue(3'h7, 8'hff, 1'b1);
    strb(1'b0, 1'b0, 1'b0);
    chk("carry_out", {7'h0, carry_out}, 8'h01);
    clk_en = 1'b0;
    issue(3'h2, 8'h0f, 1'b0);
    clk_en = 1'b1;
    strb(1'b0, 1'b0, 1'b0);
    chk("working", working_register, 8'h40);
    // strobes raised just before a freeze must stand through it
    put(3'h1, 8'h01, 1'b1);
    @(negedge sys_clk);
    op_valid = 1'b0;
    clk_en = 1'b0;
    @(negedge sys_clk);
    chk("mem_wdata", mem_wdata, 8'h03);
    strb(1'b1, 1'b1, 1'b1);
    clk_en = 1'b1;
    @(negedge sys_clk);
    strb(1'b0, 1'b0, 1'b0);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {op_valid, carry_in, op_code, operand} = '0;
    rst = 1'b1;
    clk_en = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_left_through_carry();
    t_plain_right();
    t_right_through_carry();
    t_refused();
    t_reset();
    finish_test();
  end

  // well under a hundred cycles needed; generous margin
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
